// ---- pkg/pdld_cfg.svh ----
// register map, field positions, reset values and timing counts
`ifndef PDLD_CFG_SVH
`define PDLD_CFG_SVH
`define PDLD_ADDR_NDIV 12'h000
`define PDLD_ADDR_PD 12'h004
`define PDLD_ADDR_LD 12'h008
`define PDLD_ADDR_TOUT 12'h00C
`define PDLD_ADDR_STAT 12'h010
`define PDLD_NDIV_FRAC 20
`define PDLD_PD_TRIM_LSB 0
`define PDLD_PD_UP_EN 5
`define PDLD_PD_DN_EN 6
`define PDLD_PD_FSRC 9
`define PDLD_PD_FSNK 10
`define PDLD_PD_FMID 11
`define PDLD_PD_DIV2 19
`define PDLD_LD_CNT_LSB 0
`define PDLD_LD_EN 3
`define PDLD_LD_WSEL 6
`define PDLD_LD_DIV_LSB 7
`define PDLD_LD_SPD_LSB 10
`define PDLD_TO_SEL_LSB 0
`define PDLD_TO_MODE6 6
`define PDLD_TO_MODE7 7
`define PDLD_ST_LOCK 1
`define PDLD_ST_RATIO_OK 0
`define PDLD_NDIV_RST 32'h00000010
`define PDLD_PD_RST 32'h00000060
`define PDLD_LD_RST 32'h00000005
`define PDLD_TOUT_RST 32'h00000001
`define PDLD_SEL_LOCK 5'h01
`define PDLD_SEL_NDIV 5'h0A
`define PDLD_INT_MIN 19'h00010
`define PDLD_INT_MAX 19'h7FFFF
`define PDLD_FRAC_MIN 19'h00014
`define PDLD_FRAC_MAX 19'h7FFFB
`define PDLD_CLK_MHZ 250
`define PDLD_ANA_WIN_NS 10
`define PDLD_ANA_WIN_CYC ((`PDLD_ANA_WIN_NS * `PDLD_CLK_MHZ) / 1000)
`define PDLD_LOCK_SHIFT 6
`endif

// ---- pkg/pdld_pkg.sv ----
// types shared by the phase detector and lock detect block
package pdld_pkg;
  typedef logic [31:0] pdld_word_t;
  typedef enum logic [1:0] {
    PDLD_IDLE, PDLD_REF_FIRST, PDLD_VCO_FIRST, PDLD_RESET
  } pdld_state_t;
endpackage

// ---- src/pdld_top.sv ----
// divider, phase detector, lock detector and register file with apb access
// Operation
// - integer mode divider accepts ratios 16 to 524287 from 19-bit field
// - test selector ten puts divider output on shared pin
// - with halving enabled total ratio is even, 32 to 1048574
// - three-bit field trims detector reset path delay
// - bit 5 enables pump up, bit 6 pump down
// - bit 9 forces sourcing, bit 10 forces sinking
// - bit 11 turns pump off and drives filter at midrail
// - lock enable bit 3 gates all lock detection
// - detector measures only magnitude of arrival difference
// - window select clear uses fixed 10 ns analog window
// - window select set uses digital one-shot timer window
// - two-bit speed field picks base timer period
// - three-bit divider field picks number of base periods
// - count field sets consecutive hits; 5 means 2048
// - one miss drops lock until full target met again
// - lock flag readable as status bit 1
// - selector 1 with mode bits 6,7 set drives lock flag
// - mode bit 6 clear shows lock except during serial read or with selector ten
// - window measurement starts at first arriving edge
// - divider settings mean 0.5 to 64 base periods
`timescale 1ns/100ps
`default_nettype none
`include "pdld_cfg.svh"
module pdld_top #(
  parameter int WIN_W = 12,
  parameter int HIT_W = 14,
  parameter logic [3:0] BASE_CYC0 = 4'h2,
  parameter logic [3:0] BASE_CYC1 = 4'h3,
  parameter logic [3:0] BASE_CYC2 = 4'h4,
  parameter logic [3:0] BASE_CYC3 = 4'h5
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire pdld_pkg::pdld_word_t pwdata,
  output pdld_pkg::pdld_word_t prdata,
  output logic pready,
  output logic pslverr,
  // rf and reference edges, one-cycle pulses
  input wire logic rf_tick,
  input wire logic ref_edge,
  // serial readback from the port logic
  input wire logic serial_read_active,
  input wire logic serial_data_out,
  // charge pump and pin
  output logic pump_up,
  output logic pump_down,
  output logic pump_force_midrail,
  output logic pd_reset,
  output logic ndiv_out,
  output logic lock_flag_serial_out_pin,
  output logic lock_flag_serial_out_pin_oe
);
  import pdld_pkg::*;
  // refuse counters too narrow for the longest window and hit target
  if (WIN_W < 10 || HIT_W < 14) begin : g_width_check
    $error("pdld_top: counter widths too narrow");
  end

  pdld_word_t ndiv_reg;
  pdld_word_t pd_reg;
  pdld_word_t ld_reg;
  pdld_word_t tout_reg;
  logic lock_flag;
  logic ratio_ok;
  // apb slave
  logic mapped;
  logic wr_en;
  logic rd_setup;
  pdld_word_t rd_mux;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    if (paddr == `PDLD_ADDR_NDIV) begin
      rd_mux = ndiv_reg;
    end else if (paddr == `PDLD_ADDR_PD) begin
      rd_mux = pd_reg;
    end else if (paddr == `PDLD_ADDR_LD) begin
      rd_mux = ld_reg;
    end else if (paddr == `PDLD_ADDR_TOUT) begin
      rd_mux = tout_reg;
    end else if (paddr == `PDLD_ADDR_STAT) begin
      rd_mux[`PDLD_ST_LOCK] = lock_flag;
      rd_mux[`PDLD_ST_RATIO_OK] = ratio_ok;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ndiv_reg <= `PDLD_NDIV_RST;
      pd_reg <= `PDLD_PD_RST;
      ld_reg <= `PDLD_LD_RST;
      tout_reg <= `PDLD_TOUT_RST;
    end else if (wr_en) begin
      if (paddr == `PDLD_ADDR_NDIV) begin
        ndiv_reg <= pwdata & 32'h001FFFFF;
      end else if (paddr == `PDLD_ADDR_PD) begin
        pd_reg <= pwdata & 32'h00080E67;
      end else if (paddr == `PDLD_ADDR_LD) begin
        ld_reg <= pwdata & 32'h00000FCF;
      end else if (paddr == `PDLD_ADDR_TOUT) begin
        tout_reg <= pwdata & 32'h000000DF;
      end
    end
  end
  // field decode
  logic [18:0] ratio;
  logic frac_mode;
  logic div2_en;
  logic [2:0] trim;
  logic ld_en;
  logic wsel;
  logic [2:0] ld_div;
  logic [1:0] ld_spd;
  logic [2:0] ld_cnt;
  logic [4:0] tsel;

  assign ratio = ndiv_reg[18:0];
  assign frac_mode = ndiv_reg[`PDLD_NDIV_FRAC];
  assign div2_en = pd_reg[`PDLD_PD_DIV2];
  assign trim = pd_reg[`PDLD_PD_TRIM_LSB +: 3];
  assign ld_en = ld_reg[`PDLD_LD_EN];
  assign wsel = ld_reg[`PDLD_LD_WSEL];
  assign ld_div = ld_reg[`PDLD_LD_DIV_LSB +: 3];
  assign ld_spd = ld_reg[`PDLD_LD_SPD_LSB +: 2];
  assign ld_cnt = ld_reg[`PDLD_LD_CNT_LSB +: 3];
  assign tsel = tout_reg[`PDLD_TO_SEL_LSB +: 5];

  // window length in cycles, at least one
  function automatic logic [WIN_W-1:0] win_cycles(
    input logic sel_dig, input logic [1:0] spd, input logic [2:0] dv);
    logic [3:0] base;
    logic [WIN_W:0] half;
    base = BASE_CYC0;
    half = '0;
    if (!sel_dig) begin
      win_cycles = WIN_W'(`PDLD_ANA_WIN_CYC);
    end else begin
      case (spd)
        2'h0: base = BASE_CYC0;
        2'h1: base = BASE_CYC1;
        2'h2: base = BASE_CYC2;
        default: base = BASE_CYC3;
      endcase
      half = (WIN_W+1)'(base) << dv;
      win_cycles = half[WIN_W:1];
    end
    if (win_cycles == '0) begin
      win_cycles = WIN_W'(1);
    end
  endfunction

  // consecutive-hit target, setting 5 gives 2048
  function automatic logic [HIT_W-1:0] hit_target(input logic [2:0] c);
    hit_target = HIT_W'(1) << (HIT_W'(c) + HIT_W'(`PDLD_LOCK_SHIFT));
  endfunction
  // main feedback divider
  logic [18:0] eff_ratio;
  logic [18:0] div_cnt;
  logic half_ph;
  logic div_tick;

  // programmed ratio legal for the active mode
  always_comb begin
    if (frac_mode) begin
      ratio_ok = ratio >= `PDLD_FRAC_MIN && ratio <= `PDLD_FRAC_MAX;
    end else begin
      ratio_ok = ratio >= `PDLD_INT_MIN;
    end
  end

  assign eff_ratio = (ratio < `PDLD_INT_MIN) ? `PDLD_INT_MIN : ratio;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ph <= 1'b0;
    end else if (rf_tick && div2_en) begin
      half_ph <= ~half_ph;
    end
  end

  assign div_tick = rf_tick & (~div2_en | half_ph);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 19'h00001;
      ndiv_out <= 1'b0;
    end else begin
      ndiv_out <= 1'b0;
      if (div_tick) begin
        if (div_cnt >= eff_ratio) begin
          div_cnt <= 19'h00001;
          ndiv_out <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 19'h00001;
        end
      end
    end
  end
  // phase detector
  pdld_state_t state;
  logic [2:0] rst_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PDLD_IDLE;
      rst_cnt <= 3'h0;
    end else begin
      case (state)
        PDLD_IDLE: begin
          if (ref_edge && ndiv_out) begin
            state <= PDLD_RESET;
            rst_cnt <= trim;
          end else if (ref_edge) begin
            state <= PDLD_REF_FIRST;
          end else if (ndiv_out) begin
            state <= PDLD_VCO_FIRST;
          end
        end
        PDLD_REF_FIRST: begin
          if (ndiv_out) begin
            state <= PDLD_RESET;
            rst_cnt <= trim;
          end
        end
        PDLD_VCO_FIRST: begin
          if (ref_edge) begin
            state <= PDLD_RESET;
            rst_cnt <= trim;
          end
        end
        default: begin
          if (rst_cnt == 3'h0) begin
            state <= PDLD_IDLE;
          end else begin
            rst_cnt <= rst_cnt - 3'h1;
          end
        end
      endcase
    end
  end

  logic mid;
  assign mid = pd_reg[`PDLD_PD_FMID];
  assign pd_reset = (state == PDLD_RESET);
  assign pump_force_midrail = mid;

  always_comb begin
    pump_up = (state == PDLD_REF_FIRST) & pd_reg[`PDLD_PD_UP_EN];
    pump_down = (state == PDLD_VCO_FIRST) & pd_reg[`PDLD_PD_DN_EN];
    if (pd_reg[`PDLD_PD_FSRC]) begin
      pump_up = 1'b1;
    end
    if (pd_reg[`PDLD_PD_FSNK]) begin
      pump_down = 1'b1;
    end
    if (mid) begin
      pump_up = 1'b0;
      pump_down = 1'b0;
    end
  end
  // lock detector
  logic [WIN_W-1:0] win_len;
  logic [WIN_W-1:0] win_cnt;
  logic meas;
  logic hit;
  logic miss;
  logic [HIT_W-1:0] hits;

  assign win_len = win_cycles(wsel, ld_spd, ld_div);

  always_comb begin
    hit = 1'b0;
    miss = 1'b0;
    if (!meas) begin
      // coincident edges count as zero difference
      hit = ref_edge & ndiv_out;
    end else if (win_cnt >= win_len) begin
      miss = 1'b1;
    end else if (ref_edge | ndiv_out) begin
      hit = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas <= 1'b0;
      win_cnt <= '0;
    end else if (!ld_en) begin
      meas <= 1'b0;
      win_cnt <= '0;
    end else if (!meas) begin
      if (ref_edge ^ ndiv_out) begin
        meas <= 1'b1;
        win_cnt <= WIN_W'(1);
      end
    end else if (hit || miss) begin
      meas <= 1'b0;
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + WIN_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits <= '0;
      lock_flag <= 1'b0;
    end else if (!ld_en) begin
      hits <= '0;
      lock_flag <= 1'b0;
    end else if (miss) begin
      hits <= '0;
      lock_flag <= 1'b0;
    end else if (hit) begin
      if (hits < hit_target(ld_cnt)) begin
        hits <= hits + HIT_W'(1);
      end
      if (hits + HIT_W'(1) >= hit_target(ld_cnt)) begin
        lock_flag <= 1'b1;
      end
    end
  end
  // shared pin
  logic next_pin;

  always_comb begin
    next_pin = lock_flag;
    if (tsel == `PDLD_SEL_NDIV) begin
      next_pin = ndiv_out;
    end else if (tsel == `PDLD_SEL_LOCK && tout_reg[`PDLD_TO_MODE6] &&
                 tout_reg[`PDLD_TO_MODE7]) begin
      next_pin = lock_flag;
    end else if (!tout_reg[`PDLD_TO_MODE6]) begin
      next_pin = serial_read_active ? serial_data_out : lock_flag;
    end else if (serial_read_active) begin
      next_pin = serial_data_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_flag_serial_out_pin <= 1'b0;
    end else begin
      lock_flag_serial_out_pin <= next_pin;
    end
  end

  assign lock_flag_serial_out_pin_oe = 1'b1;
endmodule
`default_nettype wire

// ---- bench/pdld_edge_model.sv ----
// reference edge model trailing the divided vco edge by a set lag
`timescale 1ns/100ps
`default_nettype none
module pdld_edge_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // edges
  input wire logic ndiv_out,
  input wire logic [6:0] lag,
  output logic rf_tick,
  output logic ref_edge
);
  logic [127:0] hist;
  // rf input runs every cycle
  assign rf_tick = 1'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist <= '0;
    end else begin
      hist <= {hist[126:0], ndiv_out};
    end
  end
  assign ref_edge = (lag == 7'h00) ? ndiv_out : hist[lag - 7'h01];
endmodule
`default_nettype wire

// ---- bench/pdld_chk.sv ----
// port checker for the detector block
`timescale 1ns/100ps
`default_nettype none
`include "pdld_cfg.svh"
module pdld_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire pdld_pkg::pdld_word_t pwdata,
  input wire pdld_pkg::pdld_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial and pump
  input wire logic serial_read_active,
  input wire logic serial_data_out,
  input wire logic pump_up,
  input wire logic pump_down,
  input wire logic pump_force_midrail,
  input wire logic lock_flag_serial_out_pin
);
  import pdld_pkg::*;
  logic [11:0] pd;
  logic [7:0] to;
  wire logic wr = psel && penable && pwrite && pready;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd <= 12'h060;
    end else if (wr && paddr == `PDLD_ADDR_PD) begin
      pd <= pwdata[11:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to <= 8'h01;
    end else if (wr && paddr == `PDLD_ADDR_TOUT) begin
      to <= pwdata[7:0];
    end
  end
  a_force_src: assert property (
    pd[9] && !pd[11] |-> pump_up) else $error("force source idle");
  a_force_snk: assert property (
    pd[10] && !pd[11] |-> pump_down) else $error("force sink idle");
  a_mid_follow: assert property (
    pump_force_midrail == pd[11]) else $error("midrail mismatch");
  a_mid_off: assert property (
    pump_force_midrail |-> !pump_up && !pump_down)
    else $error("pump on at midrail");
  a_up_gate: assert property (
    !pd[5] && !pd[9] |-> !pump_up) else $error("pump up not gated");
  a_dn_gate: assert property (
    !pd[6] && !pd[10] |-> !pump_down) else $error("pump down not gated");
  a_pin_serial: assert property (
    to == 8'h01 && serial_read_active |=>
    lock_flag_serial_out_pin == $past(serial_data_out))
    else $error("serial data not on pin");
  a_err_map: assert property (
    psel && penable && !(paddr inside {`PDLD_ADDR_NDIV, `PDLD_ADDR_PD,
    `PDLD_ADDR_LD, `PDLD_ADDR_TOUT, `PDLD_ADDR_STAT}) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_zero: assert property (
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read data not zero");
  c_mid: cover property (pump_force_midrail);
  c_err: cover property (pslverr);
  c_serial: cover property (to == 8'h01 && serial_read_active);
endmodule
bind pdld_top pdld_chk chk_u (.*);
`default_nettype wire

// ---- bench/pdld_tb_top.sv ----
// self-checking bench for the detector block
`timescale 1ns/100ps
`default_nettype none
`include "pdld_cfg.svh"
module pdld_tb_top;
  import pdld_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = '0;
  pdld_word_t pwdata = '0;
  pdld_word_t prdata, q;
  logic pready, pslverr, rf_tick, ref_edge, ndiv_out, pd_reset, e;
  logic pump_up, pump_down, pump_force_midrail;
  logic lock_flag_serial_out_pin, lock_flag_serial_out_pin_oe;
  logic serial_read_active = 1'h0;
  logic serial_data_out = 1'h0;
  logic [6:0] lag = 7'h06;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  pdld_word_t rst[4] = '{`PDLD_NDIV_RST, `PDLD_PD_RST, `PDLD_LD_RST,
    `PDLD_TOUT_RST};
  pdld_word_t rv[7] = '{32'h10, 32'hF, 32'h7FFFF, 32'h100013,
    32'h100014, 32'h17FFFB, 32'h17FFFC};
  logic [6:0] ok = 7'h35;
  pdld_top dut_u (.*);
  pdld_edge_model edge_u (.*);
  always #2 pclk = ~pclk;
  task automatic chk(input pdld_word_t g, input pdld_word_t x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input pdld_word_t d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic per();
    n = 0;
    @(posedge pclk iff ndiv_out === 1'h1);
    do begin
      @(posedge pclk);
      n++;
    end while (ndiv_out !== 1'h1);
  endtask
  task automatic lk(input int w, input logic x);
    repeat (w) @(posedge pclk);
    apb(1'h0, `PDLD_ADDR_STAT, '0);
    chk(q[1], x);
  endtask
  task end_of_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 12'(4 * i), '0);
      chk(q, rst[i]);
    end
    apb(1'h0, 12'h014, 32'hFFFFFFFF);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    for (int i = 0; i < 7; i++) begin
      apb(1'h1, `PDLD_ADDR_NDIV, rv[i]);
      apb(1'h0, `PDLD_ADDR_STAT, '0);
      chk(q[0], ok[i]);
    end
    apb(1'h1, `PDLD_ADDR_NDIV, 32'h20);
    per();
    chk(32'(n), 32'h20);
    apb(1'h1, `PDLD_ADDR_PD, 32'h80060);
    per();
    chk(32'(n), 32'h40);
    apb(1'h1, `PDLD_ADDR_PD, 32'h260);
    chk(pump_up, 1'h1);
    apb(1'h1, `PDLD_ADDR_PD, 32'h460);
    chk(pump_down, 1'h1);
    apb(1'h1, `PDLD_ADDR_PD, 32'hE60);
    chk({pump_force_midrail, pump_up, pump_down}, 3'h4);
    apb(1'h1, `PDLD_ADDR_PD, 32'h0);
    repeat (64) @(posedge pclk);
    apb(1'h1, `PDLD_ADDR_PD, 32'h60);
    lag <= 7'h00;
    apb(1'h1, `PDLD_ADDR_LD, 32'h8);
    lk(60 * 32, 1'h0);
    lk(8 * 32, 1'h1);
    chk(lock_flag_serial_out_pin, 1'h1);
    serial_read_active <= 1'h1;
    repeat (2) @(posedge pclk);
    chk(lock_flag_serial_out_pin, 1'h0);
    apb(1'h1, `PDLD_ADDR_TOUT, 32'hC1);
    @(posedge pclk);
    chk(lock_flag_serial_out_pin, 1'h1);
    serial_read_active <= 1'h0;
    apb(1'h1, `PDLD_ADDR_TOUT, 32'h01);
    lag <= 7'h06;
    lk(64, 1'h0);
    apb(1'h1, `PDLD_ADDR_LD, 32'hFC8);
    lk(72 * 32, 1'h1);
    lag <= 7'h1D;
    lk(72 * 32, 1'h1);
    lag <= 7'h1F;
    apb(1'h1, `PDLD_ADDR_LD, 32'h8);
    lk(72 * 32, 1'h1);
    apb(1'h1, `PDLD_ADDR_LD, 32'hFC0);
    lk(0, 1'h0);
    apb(1'h1, `PDLD_ADDR_TOUT, 32'h0A);
    n = 0;
    repeat (320) begin
      @(posedge pclk);
      if (lock_flag_serial_out_pin === 1'h1) n++;
    end
    chk(32'(n), 32'hA);
    end_of_test;
  end
endmodule
`default_nettype wire
